// ===== verilog/hsrc_pkg.sv
// package: constants, register map and carrier types of the heater setpoint ramp control
package hsrc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HSRC_CTRL_OFS = 8'h00;
  localparam logic [7:0] HSRC_INTEG_OFS = 8'h04;
  localparam logic [7:0] HSRC_DERIV_OFS = 8'h08;
  localparam logic [7:0] HSRC_MANUAL_OFS = 8'h0c;
  localparam logic [7:0] HSRC_SETP_OFS = 8'h10;
  localparam logic [7:0] HSRC_RATE_OFS = 8'h14;
  localparam logic [7:0] HSRC_RANGE_OFS = 8'h18;
  localparam logic [7:0] HSRC_CMD_OFS = 8'h1c;
  localparam logic [7:0] HSRC_STATUS_OFS = 8'h20;
  localparam logic [7:0] HSRC_SPLIM_OFS = 8'h24;
  localparam logic [7:0] HSRC_SENSLO_OFS = 8'h28;
  localparam logic [7:0] HSRC_SENSHI_OFS = 8'h2c;
  localparam logic [7:0] HSRC_DTIME_OFS = 8'h30;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HSRC_CTRL_MODE_LSB = 0;
  localparam int HSRC_CTRL_RAMP_BIT = 2;
  localparam int HSRC_CTRL_UNITS_BIT = 3;
  localparam int HSRC_CTRL_PWRUP_BIT = 4;
  localparam int HSRC_CMD_ALLOFF_BIT = 0;
  localparam int HSRC_CMD_MEAS_BIT = 1;
  localparam int HSRC_STAT_TRIP_LSB = 0;
  localparam int HSRC_STAT_RAMP_BIT = 4;
  localparam int HSRC_STAT_RANGE_LSB = 8;
  // ----------------------------------------------------------------
  // modes, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] HSRC_MODE_OFF = 2'h0;
  localparam logic [1:0] HSRC_MODE_CLOSED = 2'h1;
  localparam logic [1:0] HSRC_MODE_OPEN = 2'h2;
  localparam logic [7:0] HSRC_DERIV_MAX = 8'hc8;       // 200 percent
  localparam logic [13:0] HSRC_MANUAL_MAX = 14'h2710;  // 100.00 percent
  localparam logic [16:0] HSRC_RATE_MAX = 17'h186a0;   // 100.000 deg/min
  localparam logic [13:0] HSRC_INTEG_MAX = 14'h2710;   // 1000.0
  localparam logic [2:0] HSRC_RANGE_MAX = 3'h5;
  localparam logic [13:0] HSRC_INTEG_RST = 14'h00c8;   // 20.0
  localparam logic [7:0] HSRC_DERIV_RST = 8'h00;
  localparam logic [13:0] HSRC_MANUAL_RST = 14'h0000;
  localparam logic [31:0] HSRC_SETP_RST = 32'h0000_0000;
  localparam logic [16:0] HSRC_RATE_RST = 17'h00000;
  localparam logic [2:0] HSRC_RANGE_RST = 3'h0;
  localparam logic [31:0] HSRC_SPLIM_RST = 32'hffff_ffff;
  localparam logic [31:0] HSRC_SENSHI_RST = 32'hffff_ffff;
  localparam logic [31:0] HSRC_SENSLO_RST = 32'h0000_0000;
  // derivative time in 0.01 s = DTIME_SCALE * deriv / integ
  localparam logic [11:0] HSRC_DTIME_SCALE = 12'h9c4;  // 2500
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int HSRC_CLK_HZ = 40_000_000;
  localparam int HSRC_TICK_MS = 60;    // ramp update interval
  localparam int HSRC_HOLD_MS = 3000;  // setpoint key hold time
  localparam int HSRC_TICK_CYCLES = HSRC_TICK_MS * (HSRC_CLK_HZ / 1000);
  localparam int HSRC_HOLD_CYCLES = HSRC_HOLD_MS * (HSRC_CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic temp_limit;    // sensor above temperature limit
    logic setup_change;  // control input type or curve changed
    logic power_loss;    // power returned with power-up enable off
    logic sensor_err;    // over or under range reading
  } hsrc_trip_type;
  typedef struct packed {
    logic [13:0] level;   // 0.01 percent of full scale
    logic [2:0] range;    // 0 = off
    logic all_off;        // one-cycle request to switch every output off
  } hsrc_heat_type;
endpackage

// ===== verilog/hsrc_div.sv
// serial restoring divider used to rescale the derivative time
`timescale 1ns/1ps
`default_nettype none
module hsrc_div
  import hsrc_pkg::*;
#(
  parameter int NW = 20,
  parameter int DW = 14
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  // answer
  output logic busy,
  output logic [NW-1:0] quot
);
  typedef enum logic [1:0] {DIV_IDLE = 2'b01, DIV_RUN = 2'b10} hsrc_div_st_type;
  typedef struct packed {
    hsrc_div_st_type st;
    logic [NW-1:0] q;
    logic [DW:0] rem;
    logic [DW-1:0] d;
    logic [5:0] cnt;
    logic [NW-1:0] quot;
  } hsrc_div_type;
  hsrc_div_type r;
  hsrc_div_type next_r;
  logic [DW:0] trial;

  // one quotient bit per cycle, msb first
  always_comb begin
    next_r = r;
    trial = {r.rem[DW-1:0], r.q[NW-1]};
    case (r.st)
      DIV_IDLE: begin
        if (start) begin
          next_r.q = num;
          next_r.d = den;
          next_r.rem = '0;
          next_r.cnt = 6'(NW);
          next_r.st = DIV_RUN;
        end
      end
      DIV_RUN: begin
        next_r.q = {r.q[NW-2:0], 1'b0};
        if (trial >= {1'b0, r.d}) begin
          next_r.rem = trial - {1'b0, r.d};
          next_r.q[0] = 1'b1;
        end else begin
          next_r.rem = trial;
        end
        next_r.cnt = r.cnt - 6'h01;
        if (r.cnt == 6'h01) begin
          next_r.quot = {r.q[NW-2:0], next_r.q[0]};
          next_r.st = DIV_IDLE;
        end
      end
      default: next_r.st = DIV_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: DIV_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.st != DIV_IDLE);
  assign quot = r.quot;
endmodule
`default_nettype wire

// ===== verilog/hsrc_ctrl.sv
// heater setpoint ramp control: loop parameters, setpoint ramp and range shut-off
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hsrc_ctrl
  import hsrc_pkg::*;
#(
  parameter int TICK_CYCLES = HSRC_TICK_CYCLES,
  parameter int HOLD_CYCLES = HSRC_HOLD_CYCLES,
  parameter bit IS_ANALOG = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front-panel keys (asynchronous)
  input wire logic all_off_key,
  input wire logic setp_key,
  // measurement and loop side
  input wire logic [31:0] meas_value,
  input wire logic [31:0] conv_setpoint,
  input wire logic [15:0] pid_result,
  input wire hsrc_trip_type trips,
  // outputs
  output hsrc_heat_type heat,
  output logic [31:0] working_setpoint,
  output logic ramp_active,
  output logic [19:0] deriv_time
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RAMP_IDLE = 2'b01, RAMP_RUN = 2'b10} hsrc_ramp_st_type;
  typedef struct packed {
    logic [1:0] mode;
    logic ramp_en;
    logic units_sensor;
    logic pwr_up_en;
    logic [13:0] integ;
    logic [7:0] deriv;
    logic [13:0] manual;
    logic [16:0] rate;
    logic [2:0] range;
    logic [31:0] working;
    logic [31:0] target;
    hsrc_ramp_st_type ramp_st;
    logic [31:0] sp_limit;
    logic [31:0] sens_lo;
    logic [31:0] sens_hi;
    logic [31:0] tick_cnt;
    logic [31:0] hold_cnt;
    logic [1:0] alloff_sync;
    logic [1:0] key_sync;
    logic alloff_prev;
    logic [3:0] trip_seen;
    logic dirty;
    logic div_start;
    logic div_run;
    logic [19:0] dtime;
    logic [13:0] heat_level;
    logic all_off;
    logic [31:0] prdata;
  } hsrc_state_type;
  hsrc_state_type r;
  hsrc_state_type next_r;

  logic div_busy;
  logic [19:0] div_quot;
  logic acc_wr;
  logic [31:0] entry;
  logic [31:0] diff;
  logic [16:0] sum;
  logic alloff_req;
  logic key_long;
  logic [3:0] trip_vec;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address decode, shared by write and error answer
  function automatic logic hsrc_mapped(input logic [7:0] a);
    hsrc_mapped = (a[1:0] == 2'h0) && (a <= HSRC_DTIME_OFS);
  endfunction

  // entry limiting in the active unit system
  function automatic logic [31:0] hsrc_clamp(input logic [31:0] v, input logic sens,
    input logic [31:0] lim, input logic [31:0] lo, input logic [31:0] hi);
    if (!sens) begin
      hsrc_clamp = (v > lim) ? lim : v;
    end else if (v < lo) begin
      hsrc_clamp = lo;
    end else begin
      hsrc_clamp = (v > hi) ? hi : v;
    end
  endfunction

  // ----------------------------------------------------------------
  // derivative rescaling divider
  // ----------------------------------------------------------------
  hsrc_div #(.NW(20), .DW(14)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.div_start),
    .num(20'(r.deriv) * 20'(HSRC_DTIME_SCALE)),
    .den(r.integ),
    .busy(div_busy),
    .quot(div_quot)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // zero-wait apb: read data is captured in the setup cycle
  always_comb begin
    next_r = r;
    acc_wr = psel && penable && pwrite && hsrc_mapped(paddr);
    entry = hsrc_clamp(pwdata, r.units_sensor, r.sp_limit, r.sens_lo, r.sens_hi);
    diff = (r.target > r.working) ? (r.target - r.working) : (r.working - r.target);
    sum = 17'(r.manual) + 17'(pid_result > 16'(HSRC_MANUAL_MAX) ? HSRC_MANUAL_MAX
      : pid_result[13:0]);
    trip_vec = {trips.temp_limit, trips.setup_change, trips.power_loss, trips.sensor_err};
    next_r.div_start = 1'b0;
    next_r.all_off = 1'b0;

    // key synchronisers, second stage only feeds logic
    next_r.alloff_sync = {r.alloff_sync[0], all_off_key};
    next_r.key_sync = {r.key_sync[0], setp_key};
    next_r.alloff_prev = r.alloff_sync[1];
    alloff_req = r.alloff_sync[1] && !r.alloff_prev;
    if (r.key_sync[1]) begin
      next_r.hold_cnt = (r.hold_cnt == 32'(HOLD_CYCLES)) ? r.hold_cnt : r.hold_cnt + 32'h1;
    end else begin
      next_r.hold_cnt = 32'h0;
    end
    key_long = r.key_sync[1] && (r.hold_cnt == 32'(HOLD_CYCLES - 1));

    // ramp generator: fixed interval, rate as magnitude, no overshoot
    next_r.tick_cnt = (r.tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : r.tick_cnt + 32'h1;
    if (r.ramp_st == RAMP_RUN && r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      if (diff <= 32'(r.rate)) begin
        next_r.working = r.target;
      end else if (r.target > r.working) begin
        next_r.working = r.working + 32'(r.rate);
      end else begin
        next_r.working = r.working - 32'(r.rate);
      end
    end
    case (r.ramp_st)
      RAMP_IDLE: begin
        if (r.working != r.target) begin
          next_r.ramp_st = RAMP_RUN;
        end
      end
      RAMP_RUN: begin
        if (next_r.working == r.target) begin
          next_r.ramp_st = RAMP_IDLE;
        end
      end
      default: next_r.ramp_st = RAMP_IDLE;
    endcase

    // register writes
    if (acc_wr) begin
      case (paddr)
        HSRC_CTRL_OFS: begin
          next_r.mode = pwdata[HSRC_CTRL_MODE_LSB +: 2];
          next_r.ramp_en = pwdata[HSRC_CTRL_RAMP_BIT];
          next_r.pwr_up_en = pwdata[HSRC_CTRL_PWRUP_BIT];
          next_r.units_sensor = pwdata[HSRC_CTRL_UNITS_BIT];
          if (!pwdata[HSRC_CTRL_RAMP_BIT]) begin
            next_r.target = next_r.working;
          end
          if (pwdata[HSRC_CTRL_UNITS_BIT] != r.units_sensor) begin
            next_r.working = conv_setpoint;
            next_r.target = conv_setpoint;
          end
        end
        HSRC_INTEG_OFS: begin
          next_r.integ = (pwdata > 32'(HSRC_INTEG_MAX)) ? HSRC_INTEG_MAX : pwdata[13:0];
          next_r.dirty = 1'b1;
        end
        HSRC_DERIV_OFS: begin
          next_r.deriv = (pwdata > 32'(HSRC_DERIV_MAX)) ? HSRC_DERIV_MAX : pwdata[7:0];
          next_r.dirty = 1'b1;
        end
        HSRC_MANUAL_OFS: begin
          next_r.manual = (pwdata > 32'(HSRC_MANUAL_MAX)) ? HSRC_MANUAL_MAX
            : pwdata[13:0];
        end
        HSRC_SETP_OFS: begin
          if (entry == r.target) begin
            next_r.target = next_r.working;
          end else if (r.ramp_en && !r.units_sensor) begin
            next_r.target = entry;
          end else begin
            next_r.target = entry;
            next_r.working = entry;
          end
        end
        HSRC_RATE_OFS: begin
          next_r.rate = (pwdata > 32'(HSRC_RATE_MAX)) ? HSRC_RATE_MAX : pwdata[16:0];
        end
        HSRC_RANGE_OFS: begin
          if (IS_ANALOG) begin
            next_r.range = {2'h0, pwdata != 32'h0};
          end else begin
            next_r.range = (pwdata > 32'(HSRC_RANGE_MAX)) ? HSRC_RANGE_MAX
              : pwdata[2:0];
          end
        end
        HSRC_STATUS_OFS: next_r.trip_seen = r.trip_seen & ~pwdata[HSRC_STAT_TRIP_LSB +: 4];
        HSRC_SPLIM_OFS: next_r.sp_limit = pwdata;
        HSRC_SENSLO_OFS: next_r.sens_lo = pwdata;
        HSRC_SENSHI_OFS: next_r.sens_hi = pwdata;
        default: next_r.mode = next_r.mode;
      endcase
    end

    // long key press or command loads the measured value directly
    if (key_long || (acc_wr && paddr == HSRC_CMD_OFS && pwdata[HSRC_CMD_MEAS_BIT])) begin
      next_r.working = meas_value;
      next_r.target = meas_value;
    end

    // sticky trip flags, a new event wins over a clear
    next_r.trip_seen = next_r.trip_seen | trip_vec;

    // automatic shut-off conditions: trips while controlling, setup change during a ramp in any mode
    if (r.mode != HSRC_MODE_OFF && (trips.setup_change || trips.power_loss ||
      trips.sensor_err)) begin
      next_r.range = HSRC_RANGE_RST;
    end
    if (trips.setup_change && r.ramp_st == RAMP_RUN) begin
      next_r.ramp_en = 1'b0;
      next_r.target = next_r.working;
      next_r.range = HSRC_RANGE_RST;
    end
    // limit trip and all-off act in every mode
    if (trips.temp_limit || alloff_req ||
        (acc_wr && paddr == HSRC_CMD_OFS && pwdata[HSRC_CMD_ALLOFF_BIT])) begin
      next_r.range = HSRC_RANGE_RST;
      next_r.all_off = 1'b1;
    end

    // derivative time recomputed after any integral or derivative change
    if (r.dirty && !div_busy && !r.div_start) begin
      next_r.dirty = 1'b0;
      next_r.div_start = (r.integ != 14'h0);
      if (r.integ == 14'h0) begin
        next_r.dtime = 20'h0;
      end
    end
    next_r.div_run = div_busy;
    if (r.div_run && !div_busy) begin
      next_r.dtime = div_quot;
    end

    // output level: manual alone open loop, manual plus pid closed loop
    if (r.range == HSRC_RANGE_RST) begin
      next_r.heat_level = 14'h0;
    end else if (r.mode == HSRC_MODE_OPEN) begin
      next_r.heat_level = r.manual;
    end else if (r.mode == HSRC_MODE_CLOSED) begin
      next_r.heat_level = (sum > 17'(HSRC_MANUAL_MAX)) ? HSRC_MANUAL_MAX : sum[13:0];
    end else begin
      next_r.heat_level = 14'h0;
    end

    // read data captured in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        HSRC_CTRL_OFS: next_r.prdata = 32'({r.pwr_up_en, r.units_sensor, r.ramp_en, r.mode});
        HSRC_INTEG_OFS: next_r.prdata = 32'(r.integ);
        HSRC_DERIV_OFS: next_r.prdata = 32'(r.deriv);
        HSRC_MANUAL_OFS: next_r.prdata = 32'(r.manual);
        HSRC_SETP_OFS: next_r.prdata = r.working;
        HSRC_RATE_OFS: next_r.prdata = 32'(r.rate);
        HSRC_RANGE_OFS: next_r.prdata = 32'(r.range);
        HSRC_STATUS_OFS: next_r.prdata = 32'({r.range, 3'h0, r.ramp_st == RAMP_RUN,
          r.trip_seen});
        HSRC_SPLIM_OFS: next_r.prdata = r.sp_limit;
        HSRC_SENSLO_OFS: next_r.prdata = r.sens_lo;
        HSRC_SENSHI_OFS: next_r.prdata = r.sens_hi;
        HSRC_DTIME_OFS: next_r.prdata = 32'(r.dtime);
        default: next_r.prdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{mode: HSRC_MODE_OFF, integ: HSRC_INTEG_RST, deriv: HSRC_DERIV_RST,
        manual: HSRC_MANUAL_RST, rate: HSRC_RATE_RST, range: HSRC_RANGE_RST,
        working: HSRC_SETP_RST, target: HSRC_SETP_RST, ramp_st: RAMP_IDLE,
        sp_limit: HSRC_SPLIM_RST, sens_lo: HSRC_SENSLO_RST, sens_hi: HSRC_SENSHI_RST,
        default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hsrc_mapped(paddr);
  assign prdata = r.prdata;
  assign heat = '{level: r.heat_level, range: r.range, all_off: r.all_off};
  assign working_setpoint = r.working;
  assign ramp_active = (r.ramp_st == RAMP_RUN);
  assign deriv_time = r.dtime;
endmodule
`default_nettype wire

// ===== verif/hsrc_ctrl_assertions.sv
// checker: port-level properties of the heater setpoint ramp control
`timescale 1ns/1ps
`default_nettype none
module hsrc_ctrl_checker
  import hsrc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // keys and loop side
  input wire logic all_off_key,
  input wire logic setp_key,
  input wire hsrc_trip_type trips,
  // outputs
  input wire hsrc_heat_type heat,
  input wire logic [31:0] working_setpoint,
  input wire logic ramp_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setpoint write completing at this edge
  logic setp_wr;
  assign setp_wr = psel && penable && pwrite && (paddr == HSRC_SETP_OFS);

  limit_trip_off_a: assert property (trips.temp_limit |=> heat.range == 3'h0)
    else $error("range not off after limit trip");
  range_top_a: assert property (heat.range <= HSRC_RANGE_MAX)
    else $error("heater range above top range");
  level_top_a: assert property (heat.level <= HSRC_MANUAL_MAX)
    else $error("output level above full scale");
  alloff_range_a: assert property (heat.all_off |-> heat.range == 3'h0)
    else $error("all off pulse with range on");
  alloff_pulse_a: assert property (heat.all_off |=> !heat.all_off)
    else $error("all off pulse longer than one cycle");
  alloff_key_a: assert property ($rose(all_off_key) |-> ##[1:6] heat.all_off)
    else $error("all off key ignored");
  ramp_cause_a: assert property ($rose(ramp_active) |->
    $past(setp_wr) || $past(setp_wr, 2) || $past(setp_wr, 3))
    else $error("ramp started without setpoint entry");
  // idle generator must not move the working setpoint on its own
  working_hold_a: assert property (!ramp_active && !psel && !$past(psel)
    && !setp_key && !$past(setp_key) |=> $stable(working_setpoint))
    else $error("working setpoint moved while idle");
endmodule
bind hsrc_ctrl hsrc_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .all_off_key(all_off_key),
  .setp_key(setp_key), .trips(trips), .heat(heat), .working_setpoint(working_setpoint),
  .ramp_active(ramp_active));
`default_nettype wire

// ===== verif/hsrc_load_model.sv
// partner: heater load, sensor reading, curve conversion and fault source
`timescale 1ns/1ps
`default_nettype none
module hsrc_load_model
  import hsrc_pkg::*;
#(
  parameter logic [15:0] PID_LEVEL = 16'h01f4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drive from the block
  input wire hsrc_heat_type heat,
  input wire logic [31:0] working_setpoint,
  // faults commanded by the bench
  input wire hsrc_trip_type fault_req,
  // sensor side
  output logic [31:0] meas_value,
  output logic [31:0] conv_setpoint,
  output logic [15:0] pid_result,
  output hsrc_trip_type trips
);
  // load warms only while a range is on, so a reading taken off stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_value <= 32'h0000_3a98;
    end else if (heat.range != 3'h0) begin
      meas_value <= meas_value + {29'h0, heat.range};
    end
  end
  // curve stand-in: a fixed offset makes a units swap visible
  assign conv_setpoint = working_setpoint + 32'h0000_0100;
  assign pid_result = PID_LEVEL;
  assign trips = fault_req;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// testbench: directed scenarios for the heater setpoint ramp control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hsrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, all_off_key, setp_key, ramp_active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, meas_value, conv_setpoint, working_setpoint, rdata, w;
  logic [15:0] pid_result;
  logic [19:0] deriv_time;
  logic rerr;
  hsrc_trip_type trips, fault_req;
  hsrc_heat_type heat;
  int errors, checks;

  hsrc_ctrl #(.TICK_CYCLES(20), .HOLD_CYCLES(50)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .all_off_key(all_off_key),
    .setp_key(setp_key), .meas_value(meas_value), .conv_setpoint(conv_setpoint),
    .pid_result(pid_result), .trips(trips), .heat(heat), .working_setpoint(working_setpoint),
    .ramp_active(ramp_active), .deriv_time(deriv_time));
  hsrc_load_model load (.pclk(pclk), .presetn(presetn), .heat(heat),
    .working_setpoint(working_setpoint), .fault_req(fault_req), .meas_value(meas_value),
    .conv_setpoint(conv_setpoint), .pid_result(pid_result), .trips(trips));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ------------------------------------------------
  // bus and compare helpers
  // ------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask
  task automatic fault(input hsrc_trip_type f);
    @(posedge pclk);
    fault_req <= f;
    @(posedge pclk);
    fault_req <= '0;
    cyc(2);
  endtask
  // bounded wait for ramp end
  task automatic wait_idle();
    repeat (400) begin
      @(posedge pclk);
      if (ramp_active === 1'b0) break;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_regs();
    rchk(HSRC_INTEG_OFS, 32'h0000_00c8, "integ reset");
    rchk(HSRC_DERIV_OFS, 32'h0, "deriv reset");
    rchk(HSRC_MANUAL_OFS, 32'h0, "manual reset");
    wr(HSRC_DERIV_OFS, 32'h0000_00ff);
    rchk(HSRC_DERIV_OFS, 32'h0000_00c8, "deriv clamp");
    wr(HSRC_MANUAL_OFS, 32'h0000_4e20);
    rchk(HSRC_MANUAL_OFS, 32'h0000_2710, "manual clamp");
    wr(HSRC_RATE_OFS, 32'h0003_0d40);
    rchk(HSRC_RATE_OFS, 32'h0001_86a0, "rate clamp");
    rchk(8'h34, 32'h0, "unmapped read");
    chk("unmapped err", 32'h1, 32'(rerr));
  endtask
  task automatic t_deriv();
    wr(HSRC_DERIV_OFS, 32'h0000_0064);
    cyc(40);
    chk("dtime", HSRC_DTIME_SCALE * 100 / 200, {12'h0, deriv_time});
    wr(HSRC_INTEG_OFS, 32'h0000_0064);
    cyc(40);
    chk("dtime rescale", HSRC_DTIME_SCALE * 100 / 100, {12'h0, deriv_time});
  endtask
  task automatic t_loop();
    wr(HSRC_MANUAL_OFS, 32'h0000_04d2);
    wr(HSRC_RANGE_OFS, 32'h1);
    wr(HSRC_CTRL_OFS, 32'h2);
    cyc(3);
    chk("open level", 32'h0000_04d2, 32'(heat.level));
    wr(HSRC_CTRL_OFS, 32'h1);
    cyc(3);
    chk("closed level", 32'h0000_04d2 + 32'h01f4, 32'(heat.level));
  endtask
  task automatic t_range();
    wr(HSRC_RANGE_OFS, 32'h7);
    rchk(HSRC_RANGE_OFS, 32'h5, "range clamp");
    fault('{temp_limit: 1'b1, default: 1'b0});
    chk("limit off", 32'h0, 32'(heat.range));
    rchk(HSRC_STATUS_OFS, 32'h8, "limit flag");
    wr(HSRC_RANGE_OFS, 32'h3);
    fault('{sensor_err: 1'b1, default: 1'b0});
    chk("sensor trip off", 32'h0, 32'(heat.range));
    wr(HSRC_RANGE_OFS, 32'h3);
    wr(HSRC_CMD_OFS, 32'h1);
    cyc(2);
    chk("cmd all off", 32'h0, 32'(heat.range));
    wr(HSRC_RANGE_OFS, 32'h3);
    @(posedge pclk);
    all_off_key <= 1'b1;
    cyc(8);
    all_off_key <= 1'b0;
    chk("key all off", 32'h0, 32'(heat.range));
  endtask
  task automatic t_ramp();
    wr(HSRC_RATE_OFS, 32'h0000_03e8);
    wr(HSRC_CTRL_OFS, 32'h5);
    wr(HSRC_SETP_OFS, 32'h0000_1194);
    cyc(30);
    chk("ramp on", 32'h1, 32'(ramp_active));
    chk("step size", 32'h0, working_setpoint % 1000);
    chk("below target", 32'h1, 32'(working_setpoint < 32'h0000_1194));
    wait_idle();
    chk("ramp end", 32'h0000_1194, working_setpoint);
    wr(HSRC_SETP_OFS, 32'h0000_03e8);
    cyc(30);
    chk("ramp down", 32'h1, 32'(working_setpoint > 32'h0000_03e8));
    wait_idle();
    chk("down end", 32'h0000_03e8, working_setpoint);
  endtask
  task automatic t_halt();
    wr(HSRC_SETP_OFS, 32'h0000_4e20);
    cyc(45);
    wr(HSRC_SETP_OFS, 32'h0000_4e20);
    cyc(3);
    w = working_setpoint;
    cyc(50);
    chk("halted", w, working_setpoint);
    rchk(HSRC_CTRL_OFS, 32'h5, "ramp kept on");
    wr(HSRC_SETP_OFS, 32'h0000_4e20);
    cyc(30);
    chk("resumed", 32'h1, 32'(ramp_active));
    wr(HSRC_CTRL_OFS, 32'h1);
    cyc(2);
    w = working_setpoint;
    cyc(50);
    chk("ramp off holds", w, working_setpoint);
  endtask
  task automatic t_units();
    w = working_setpoint;
    wr(HSRC_CTRL_OFS, 32'hd);
    cyc(2);
    chk("units convert", w + 32'h0000_0100, working_setpoint);
    wr(HSRC_SETP_OFS, 32'h0000_1b58);
    cyc(3);
    chk("sensor direct", 32'h0000_1b58, working_setpoint);
    rchk(HSRC_CTRL_OFS, 32'hd, "ramp stays on");
    wr(HSRC_SENSHI_OFS, 32'h0000_1770);
    wr(HSRC_SETP_OFS, 32'h0000_2328);
    cyc(2);
    chk("sensor clamp", 32'h0000_1770, working_setpoint);
    wr(HSRC_CTRL_OFS, 32'h1);
    wr(HSRC_SPLIM_OFS, 32'h0000_1f40);
    wr(HSRC_SETP_OFS, 32'h0000_2328);
    cyc(2);
    chk("curve clamp", 32'h0000_1f40, working_setpoint);
  endtask
  task automatic t_setup();
    wr(HSRC_CTRL_OFS, 32'h5);
    wr(HSRC_RANGE_OFS, 32'h2);
    wr(HSRC_SETP_OFS, 32'h0);
    cyc(30);
    fault('{setup_change: 1'b1, default: 1'b0});
    chk("setup off", 32'h0, 32'(heat.range));
    rchk(HSRC_CTRL_OFS, 32'h1, "ramp disabled");
    w = working_setpoint;
    cyc(50);
    chk("setup holds", w, working_setpoint);
  endtask
  task automatic t_key();
    wr(HSRC_CTRL_OFS, 32'h5);
    @(posedge pclk);
    setp_key <= 1'b1;
    cyc(60);
    setp_key <= 1'b0;
    cyc(2);
    chk("key load", meas_value, working_setpoint);
    chk("key no ramp", 32'h0, 32'(ramp_active));
  endtask

  initial begin
    {presetn, psel, penable, pwrite, all_off_key, setp_key} = 6'h0;
    {paddr, pwdata} = '0;
    fault_req = '0;
    errors = 0;
    checks = 0;
    cyc(20);
    presetn <= 1'b1;
    t_regs();
    t_deriv();
    t_loop();
    t_range();
    t_ramp();
    t_halt();
    t_units();
    t_setup();
    t_key();
    close_out();
  end
  // watchdog: run needs ~800 cycles
  initial begin
    cyc(20000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
